//--- hdl/dsb_ddr_device.sv
// DDR SDRAM device-side command, bank and burst data logic with AXI4-Lite config
// Behaviour
// R01: Commands sampled and registered only at positive link clock edges.
// R02: Positive edge is true clock rising while complement clock falls.
// R03: Write data captured on both rising and falling strobe edges.
// R04: Read data launched on both strobe edges, aligned to both clock edges.
// R05: Device drives strobe during reads; controller drives it during writes.
// R06: Read strobe edges coincide with data edges; write strobe centred.
// R07: Sixteen-bit variant uses separate lower and upper byte strobes.
// R08: Lower strobe and mask serve data bits 0-7, upper ones 8-15.
// R09: Burst length programmable to 2, 4 or 8 locations.
// R10: Burst starts at chosen column, follows programmed length and ordering.
// R11: Controller activates a row before reading or writing that bank.
// R12: Activate latches bank select and address as bank and row.
// R13: Read or write latches bank select and address as start column.
// R14: Row uses A0-A12; column bits depend on data width variant.
// R15: Auto precharge closes the accessed row by itself after the burst.
// R16: Four independent banks; activity in one overlaps another.
// R17: Each core access moves a double word; pins show two half transfers.
// R18: First read data appears 2 or 2.5 clocks after the read command.
// R19: Controller operates device with its delay-locked loop enabled.
// R20: Write word discarded when its mask is high, mask sampled on both edges.
// R21: Commands ignored while chip select high; select is part of the code.
// R22: Precharge closes one bank with A10 low, all banks with A10 high.
// R23: Controller holds clock enable high throughout read and write accesses.
// R24: No-operation cycles leave the device state unchanged.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module dsb_ddr_device #(
	parameter int ROW_KEEP = 2,
	parameter int COL_KEEP = 6
) (
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        CLOCK_TRUE,
	input  wire logic        CLOCK_COMPLEMENT,
	input  wire logic        CLOCK_ENABLE,
	input  wire logic        CHIP_SEL_N,
	input  wire logic        ROW_STROBE_N,
	input  wire logic        COL_STROBE_N,
	input  wire logic        WRITE_EN_N,
	input  wire logic [1:0]  BANK_SEL,
	input  wire logic [12:0] ADDR,
	input  wire logic [15:0] DATA_I,
	output      logic [15:0] DATA_O,
	output      logic        DATA_OE,
	input  wire logic [1:0]  STROBE_I,
	output      logic [1:0]  STROBE_O,
	output      logic [1:0]  STROBE_OE,
	input  wire logic [1:0]  WRITE_MASK,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output      logic        S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output      logic        S_AXI_WREADY,
	output      logic [1:0]  S_AXI_BRESP,
	output      logic        S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output      logic        S_AXI_ARREADY,
	output      logic [31:0] S_AXI_RDATA,
	output      logic [1:0]  S_AXI_RRESP,
	output      logic        S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY
);
	localparam int MEM_AW = 2 + ROW_KEEP + COL_KEEP;

	dsb_pkg::dsb_state_t st_r;
	dsb_pkg::dsb_state_t st_nxt;
	dsb_pkg::dsb_pins_t  pins_raw;
	dsb_pkg::dsb_pins_t  pins_s;

	logic [15:0]       mem [0:(1<<MEM_AW)-1];
	logic              mem_we;
	logic [MEM_AW-1:0] mem_wa0;
	logic [MEM_AW-1:0] mem_wa1;
	logic [15:0]       mem_wd0;
	logic [15:0]       mem_wd1;
	logic [1:0]        mem_be0;
	logic [1:0]        mem_be1;
	logic [15:0]       wr_word;
	logic [1:0]        wr_keepv;
	logic [31:0]       rd_fetch;
	logic [15:0]       rd_word;

	logic        link_edge;
	logic        pos_edge;
	logic        lo_rise;
	logic        lo_fall;
	logic        up_edge;
	logic        cmd_ok;
	logic [2:0]  cmd_code;
	logic [3:0]  bl;
	logic [15:0] lanes;
	logic [1:0]  stb_lanes;

	function automatic logic [3:0] bl_beats(input logic [1:0] code);
		case (code)
			dsb_pkg::BL_CODE_8: bl_beats = 4'h8;
			dsb_pkg::BL_CODE_4: bl_beats = 4'h4;
			default:            bl_beats = 4'h2;
		endcase
	endfunction : bl_beats

	// R14 column bits per width
	function automatic logic [11:0] col_of(input logic [12:0] a, input logic [1:0] wid);
		case (wid)
			dsb_pkg::WID_X4: col_of = {a[12], a[11], a[9:0]};
			dsb_pkg::WID_X8: col_of = {1'b0, a[11], a[9:0]};
			default:         col_of = {2'h0, a[9:0]};
		endcase
	endfunction : col_of

	// R10 wrap within burst block
	function automatic logic [11:0] burst_col(input logic [11:0] start, input logic [3:0] beat,
		input logic [3:0] len, input logic ilv);
		logic [11:0] m;
		logic [11:0] low;
		m   = {8'h00, len - 4'h1};
		low = ilv ? (start ^ {8'h00, beat}) : (start + {8'h00, beat});
		burst_col = (start & ~m) | (low & m);
	endfunction : burst_col

	// Storage is a small window of the array: low row and column bits only
	function automatic logic [MEM_AW-1:0] mem_idx(input logic [1:0] b, input logic [12:0] r,
		input logic [11:0] c);
		mem_idx = {b, r[ROW_KEEP-1:0], c[COL_KEEP-1:0]};
	endfunction : mem_idx

	assign pins_raw = '{clk_t: CLOCK_TRUE, clk_c: CLOCK_COMPLEMENT, cke: CLOCK_ENABLE,
		cmd: '{cs_n: CHIP_SEL_N, ras_n: ROW_STROBE_N, cas_n: COL_STROBE_N,
		we_n: WRITE_EN_N, bank: BANK_SEL, addr: ADDR},
		stb: STROBE_I, mask: WRITE_MASK, data: DATA_I};

	dsb_sync #(
		.W ($bits(dsb_pkg::dsb_pins_t))
	) u_sync (
		.clk   (CLK),
		.rst_n (RST_N),
		.d     (pins_raw),
		.q     (pins_s)
	);

	assign link_edge = pins_s.clk_t != st_r.ck_t_q;
	// R02 crossing of true rising and complement falling
	assign pos_edge  = pins_s.clk_t && !st_r.ck_t_q && !pins_s.clk_c && st_r.ck_c_q;
	assign lo_rise   = pins_s.stb[0] && !st_r.stb_q[0];
	assign lo_fall   = !pins_s.stb[0] && st_r.stb_q[0];
	assign up_edge   = pins_s.stb[1] != st_r.stb_q[1];
	// R21 select gates decoder; R23 clock enable assumed high during accesses
	assign cmd_ok    = pos_edge && pins_s.cke && !pins_s.cmd.cs_n;
	assign cmd_code  = {pins_s.cmd.ras_n, pins_s.cmd.cas_n, pins_s.cmd.we_n};
	assign bl        = bl_beats(st_r.cfg.bl_code);
	assign lanes     = (st_r.cfg.width == dsb_pkg::WID_X4) ? 16'h000F :
		(st_r.cfg.width == dsb_pkg::WID_X8) ? 16'h00FF : 16'hFFFF;
	// R07 upper strobe only on the sixteen-bit variant
	assign stb_lanes = (st_r.cfg.width == dsb_pkg::WID_X16) ? 2'h3 : 2'h1;

	always_comb begin
		st_nxt   = st_r;
		mem_we   = 1'b0;
		mem_wa0  = '0;
		mem_wa1  = '0;
		mem_wd0  = '0;
		mem_wd1  = '0;
		mem_be0  = '0;
		mem_be1  = '0;
		rd_fetch = '0;
		rd_word  = '0;
		st_nxt.ck_t_q = pins_s.clk_t;
		st_nxt.ck_c_q = pins_s.clk_c;
		st_nxt.stb_q  = pins_s.stb;
		// R08 upper byte and mask follow the upper strobe
		if (up_edge) begin
			st_nxt.up_data = pins_s.data[15:8];
			st_nxt.up_mask = pins_s.mask[1];
		end
		wr_word  = {up_edge ? pins_s.data[15:8] : st_r.up_data, pins_s.data[7:0]};
		// R20 masked bytes are not kept
		wr_keepv = {(st_r.cfg.width == dsb_pkg::WID_X16) &&
			!(up_edge ? pins_s.mask[1] : st_r.up_mask), !pins_s.mask[0]};
		// R03 even beats on rising, odd beats on falling strobe
		if (st_r.wr_act && ((lo_rise && !st_r.wr_beat[0]) || (lo_fall && st_r.wr_beat[0]))) begin
			if (!st_r.wr_beat[0]) begin
				st_nxt.wr_hold = wr_word;
				st_nxt.wr_keep = wr_keepv;
			end else begin
				// R17 two beats commit as one double-width core write
				mem_we  = 1'b1;
				mem_wa0 = mem_idx(st_r.wr_bank, st_r.row[st_r.wr_bank], burst_col(st_r.wr_col,
					st_r.wr_beat - 4'h1, bl, st_r.cfg.ilv));
				mem_wa1 = mem_idx(st_r.wr_bank, st_r.row[st_r.wr_bank], burst_col(st_r.wr_col,
					st_r.wr_beat, bl, st_r.cfg.ilv));
				mem_wd0 = st_r.wr_hold;
				mem_be0 = st_r.wr_keep;
				mem_wd1 = wr_word;
				mem_be1 = wr_keepv;
			end
			st_nxt.wr_beat = st_r.wr_beat + 4'h1;
			// R09 burst ends after programmed beats
			if (st_nxt.wr_beat == bl) begin
				st_nxt.wr_act = 1'b0;
				// R15 self-timed precharge after write burst
				if (st_r.wr_ap) begin
					st_nxt.open[st_r.wr_bank] = 1'b0;
				end
			end
		end
		// R04 read beats move on every link clock edge
		if (st_r.rd_act && link_edge) begin
			if (st_r.rd_lat > 3'h1) begin
				st_nxt.rd_lat = st_r.rd_lat - 3'h1;
				// R05 device takes the strobe with a low preamble
				if (st_r.rd_lat == dsb_pkg::PRE_EDGES + 3'h1) begin
					st_nxt.stb_oe = stb_lanes;
					st_nxt.stb_o  = 2'h0;
				end
			end else if (st_r.rd_beat != bl) begin
				st_nxt.rd_lat = 3'h0;
				// R17 one core fetch feeds two pin beats
				if (!st_r.rd_beat[0]) begin
					rd_fetch = {mem[mem_idx(st_r.rd_bank, st_r.row[st_r.rd_bank],
						burst_col(st_r.rd_col, st_r.rd_beat + 4'h1, bl, st_r.cfg.ilv))],
						mem[mem_idx(st_r.rd_bank, st_r.row[st_r.rd_bank],
						burst_col(st_r.rd_col, st_r.rd_beat, bl, st_r.cfg.ilv))]};
					st_nxt.rd_pair = rd_fetch;
					rd_word = rd_fetch[15:0];
				end else begin
					rd_word = st_r.rd_pair[31:16];
				end
				// R06 strobe toggles in the same cycle as the data
				st_nxt.dq_o    = rd_word & lanes;
				st_nxt.dq_oe   = 1'b1;
				st_nxt.stb_o   = {2{~st_r.rd_beat[0]}} & stb_lanes;
				st_nxt.stb_oe  = stb_lanes;
				st_nxt.rd_beat = st_r.rd_beat + 4'h1;
			end else begin
				st_nxt.rd_act = 1'b0;
				st_nxt.dq_oe  = 1'b0;
				st_nxt.dq_o   = 16'h0000;
				st_nxt.stb_oe = 2'h0;
				st_nxt.stb_o  = 2'h0;
				// R15 self-timed precharge after read burst
				if (st_r.rd_ap) begin
					st_nxt.open[st_r.rd_bank] = 1'b0;
				end
			end
		end
		// R01 commands only at the positive edge; R16 each bank tracked alone
		if (cmd_ok) begin
			case (cmd_code)
				dsb_pkg::CMD_ACT: begin
					// R12 bank and row latched
					st_nxt.row[pins_s.cmd.bank]  = pins_s.cmd.addr;
					st_nxt.open[pins_s.cmd.bank] = 1'b1;
				end
				dsb_pkg::CMD_RD: begin
					// R11 access to a closed bank is ignored
					if (st_r.open[pins_s.cmd.bank]) begin
						st_nxt.rd_act  = 1'b1;
						// R18 latency in link half-cycles
						st_nxt.rd_lat  = st_r.cfg.cl_half ? dsb_pkg::LAT_EDGES_25 :
							dsb_pkg::LAT_EDGES_2;
						st_nxt.rd_beat = 4'h0;
						// R13 bank and start column latched
						st_nxt.rd_bank = pins_s.cmd.bank;
						st_nxt.rd_col  = col_of(pins_s.cmd.addr, st_r.cfg.width);
						st_nxt.rd_ap   = pins_s.cmd.addr[dsb_pkg::AP_BIT];
					end
				end
				dsb_pkg::CMD_WR: begin
					if (st_r.open[pins_s.cmd.bank]) begin
						st_nxt.wr_act  = 1'b1;
						st_nxt.wr_beat = 4'h0;
						st_nxt.wr_bank = pins_s.cmd.bank;
						st_nxt.wr_col  = col_of(pins_s.cmd.addr, st_r.cfg.width);
						st_nxt.wr_ap   = pins_s.cmd.addr[dsb_pkg::AP_BIT];
					end
				end
				dsb_pkg::CMD_PRE: begin
					// R22 one bank or all banks
					if (pins_s.cmd.addr[dsb_pkg::AP_BIT]) begin
						st_nxt.open = '0;
					end else begin
						st_nxt.open[pins_s.cmd.bank] = 1'b0;
					end
				end
				// R24 no-operation and uncovered commands change nothing
				default: begin
				end
			endcase
		end
		// AXI4-Lite write: address and data in either order, one at a time
		if (st_r.awready && S_AXI_AWVALID) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = S_AXI_AWADDR;
		end
		if (st_r.wready && S_AXI_WVALID) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = S_AXI_WDATA;
			st_nxt.wstrb = S_AXI_WSTRB;
		end
		if (st_r.bvalid && S_AXI_BREADY) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = dsb_pkg::RESP_SLVERR;
			if (st_r.awaddr == dsb_pkg::OFS_CFG) begin
				st_nxt.bresp = dsb_pkg::RESP_OKAY;
				// All fields sit in byte 0; other lanes are ignored
				if (st_r.wstrb[0]) begin
					st_nxt.cfg.bl_code = st_r.wdata[dsb_pkg::CFG_BL_LSB +: 2];
					st_nxt.cfg.cl_half = st_r.wdata[dsb_pkg::CFG_CL_BIT];
					st_nxt.cfg.ilv     = st_r.wdata[dsb_pkg::CFG_ILV_BIT];
					st_nxt.cfg.width   = st_r.wdata[dsb_pkg::CFG_WID_LSB +: 2];
				end
			end
		end
		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
		// AXI4-Lite read: answer one cycle after the address is taken
		if (st_r.rvalid && S_AXI_RREADY) begin
			st_nxt.rvalid = 1'b0;
		end
		if (st_r.arready && S_AXI_ARVALID) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = 32'h0000_0000;
			st_nxt.rresp  = dsb_pkg::RESP_OKAY;
			if (S_AXI_ARADDR == dsb_pkg::OFS_CFG) begin
				st_nxt.rdata[5:0] = {st_r.cfg.width, st_r.cfg.ilv, st_r.cfg.cl_half,
					st_r.cfg.bl_code};
			end else if (S_AXI_ARADDR == dsb_pkg::OFS_STATUS) begin
				st_nxt.rdata[3:0] = st_r.open;
				st_nxt.rdata[dsb_pkg::STS_RD_BIT] = st_r.rd_act;
				st_nxt.rdata[dsb_pkg::STS_WR_BIT] = st_r.wr_act;
			end else begin
				st_nxt.rresp = dsb_pkg::RESP_SLVERR;
				for (int i = 0; i < dsb_pkg::BANKS; i++) begin
					if (S_AXI_ARADDR == dsb_pkg::OFS_ROW0 + 8'(4 * i)) begin
						st_nxt.rdata[12:0] = st_r.row[i];
						st_nxt.rresp       = dsb_pkg::RESP_OKAY;
					end
				end
			end
		end
		st_nxt.arready = !st_nxt.rvalid;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r <= dsb_pkg::ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Array has no reset; contents are undefined until written
	always_ff @(posedge CLK) begin
		if (mem_we) begin
			if (mem_be0[0]) mem[mem_wa0][7:0]  <= mem_wd0[7:0];
			if (mem_be0[1]) mem[mem_wa0][15:8] <= mem_wd0[15:8];
			if (mem_be1[0]) mem[mem_wa1][7:0]  <= mem_wd1[7:0];
			if (mem_be1[1]) mem[mem_wa1][15:8] <= mem_wd1[15:8];
		end
	end

	assign DATA_O        = st_r.dq_o;
	assign DATA_OE       = st_r.dq_oe;
	assign STROBE_O      = st_r.stb_o;
	assign STROBE_OE     = st_r.stb_oe;
	assign S_AXI_AWREADY = st_r.awready;
	assign S_AXI_WREADY  = st_r.wready;
	assign S_AXI_BVALID  = st_r.bvalid;
	assign S_AXI_BRESP   = st_r.bresp;
	assign S_AXI_ARREADY = st_r.arready;
	assign S_AXI_RVALID  = st_r.rvalid;
	assign S_AXI_RDATA   = st_r.rdata;
	assign S_AXI_RRESP   = st_r.rresp;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_rd_end;
		st_r.rd_act && link_edge && st_r.rd_lat <= 3'h1 && st_r.rd_beat == bl;
	endsequence
	sequence s_pre_all;
		cmd_ok && cmd_code == dsb_pkg::CMD_PRE && pins_s.cmd.addr[dsb_pkg::AP_BIT];
	endsequence

	property p_cmd_edge;
		$changed(st_r.row) |-> $past(pos_edge);
	endproperty
	a_cmd_edge: assert property (p_cmd_edge) else $error("row changed off clock edge"); // R01
	property p_pos_def;
		pos_edge |=> st_r.ck_t_q && !st_r.ck_c_q && !pos_edge;
	endproperty
	a_pos_def: assert property (p_pos_def) else $error("bad positive edge"); // R02
	property p_wr_beat;
		st_r.wr_act && lo_fall && st_r.wr_beat[0] |=>
			st_r.wr_beat == $past(st_r.wr_beat) + 4'h1 || $past(cmd_ok);
	endproperty
	a_wr_beat: assert property (p_wr_beat) else $error("write beat not counted"); // R03
	property p_rd_launch;
		$changed(st_r.stb_o) |-> $past(link_edge);
	endproperty
	a_rd_launch: assert property (p_rd_launch) else $error("strobe moved off edge"); // R04
	property p_stb_dir;
		(|st_r.stb_oe) |-> st_r.rd_act;
	endproperty
	a_stb_dir: assert property (p_stb_dir) else $error("strobe driven outside read"); // R05
	property p_edge_align;
		$changed(st_r.dq_o) && st_r.dq_oe && $past(st_r.dq_oe) |-> $changed(st_r.stb_o[0]);
	endproperty
	a_edge_align: assert property (p_edge_align) else $error("data moved without strobe"); // R06
	property p_upper_lane;
		st_r.cfg.width != dsb_pkg::WID_X16 |-> !st_r.stb_oe[1] && st_r.dq_o[15:8] == 8'h00;
	endproperty
	a_upper_lane: assert property (p_upper_lane) else $error("upper byte used"); // R08
	property p_burst_len;
		st_r.wr_beat <= 4'h8 && st_r.rd_beat <= 4'h8;
	endproperty
	a_burst_len: assert property (p_burst_len) else $error("burst overran"); // R09
	property p_auto_pre;
		s_rd_end ##0 (st_r.rd_ap && !cmd_ok) |=> !st_r.open[$past(st_r.rd_bank)];
	endproperty
	a_auto_pre: assert property (p_auto_pre) else $error("auto precharge missed"); // R15
	property p_latency;
		$rose(st_r.dq_oe) |-> $past(st_r.rd_lat) == 3'h1;
	endproperty
	a_latency: assert property (p_latency) else $error("read data early"); // R18
	property p_deselect;
		pos_edge && pins_s.cmd.cs_n |=> $stable(st_r.row) && !$rose(st_r.wr_act);
	endproperty
	a_deselect: assert property (p_deselect) else $error("command taken while deselected"); // R21
	property p_pre_all;
		s_pre_all |=> st_r.open == 4'h0;
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("precharge all failed"); // R22
	property p_nop;
		cmd_ok && cmd_code == dsb_pkg::CMD_NOP |=> $stable(st_r.row) && !$rose(st_r.rd_act);
	endproperty
	a_nop: assert property (p_nop) else $error("no-operation changed state"); // R24

endmodule : dsb_ddr_device

//--- hdl/dsb_pkg.sv
// Shared constants, carriers and state layout for the DDR device-side burst interface
package dsb_pkg;

	localparam int BANKS  = 4;
	localparam int ADDR_W = 13;
	localparam int COL_W  = 12;
	localparam int AP_BIT = 10;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_CFG    = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ROW0   = 8'h10;

	// Configuration and status register field positions
	localparam int CFG_BL_LSB  = 0;
	localparam int CFG_CL_BIT  = 2;
	localparam int CFG_ILV_BIT = 3;
	localparam int CFG_WID_LSB = 4;
	localparam int STS_RD_BIT  = 8;
	localparam int STS_WR_BIT  = 9;

	localparam logic [1:0] BL_CODE_2 = 2'h1;
	localparam logic [1:0] BL_CODE_4 = 2'h2;
	localparam logic [1:0] BL_CODE_8 = 2'h3;
	localparam logic [1:0] WID_X4    = 2'h0;
	localparam logic [1:0] WID_X8    = 2'h1;
	localparam logic [1:0] WID_X16   = 2'h2;

	// Read latency in link half-cycles, and strobe preamble length
	localparam logic [2:0] LAT_EDGES_2  = 3'h4;
	localparam logic [2:0] LAT_EDGES_25 = 3'h5;
	localparam logic [2:0] PRE_EDGES    = 3'h2;

	// Command code {row strobe, column strobe, write enable}, all active low
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_RD  = 3'h5;
	localparam logic [2:0] CMD_WR  = 3'h4;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_NOP = 3'h7;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] bl_code;
		logic       cl_half;
		logic       ilv;
		logic [1:0] width;
	} dsb_cfg_t;

	localparam dsb_cfg_t CFG_RST = '{bl_code: BL_CODE_4, cl_half: 1'b0, ilv: 1'b0,
		width: WID_X16};

	typedef struct packed {
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic [1:0]        bank;
		logic [ADDR_W-1:0] addr;
	} dsb_cmd_t;

	typedef struct packed {
		logic        clk_t;
		logic        clk_c;
		logic        cke;
		dsb_cmd_t    cmd;
		logic [1:0]  stb;
		logic [1:0]  mask;
		logic [15:0] data;
	} dsb_pins_t;

	typedef struct packed {
		logic                         ck_t_q;
		logic                         ck_c_q;
		logic [1:0]                   stb_q;
		logic [7:0]                   up_data;
		logic                         up_mask;
		dsb_cfg_t                     cfg;
		logic [BANKS-1:0]             open;
		logic [BANKS-1:0][ADDR_W-1:0] row;
		logic                         rd_act;
		logic [2:0]                   rd_lat;
		logic [3:0]                   rd_beat;
		logic [1:0]                   rd_bank;
		logic [COL_W-1:0]             rd_col;
		logic                         rd_ap;
		logic [31:0]                  rd_pair;
		logic                         wr_act;
		logic [3:0]                   wr_beat;
		logic [1:0]                   wr_bank;
		logic [COL_W-1:0]             wr_col;
		logic                         wr_ap;
		logic [15:0]                  wr_hold;
		logic [1:0]                   wr_keep;
		logic [15:0]                  dq_o;
		logic                         dq_oe;
		logic [1:0]                   stb_o;
		logic [1:0]                   stb_oe;
		logic                         aw_got;
		logic                         w_got;
		logic [7:0]                   awaddr;
		logic [31:0]                  wdata;
		logic [3:0]                   wstrb;
		logic                         awready;
		logic                         wready;
		logic                         bvalid;
		logic [1:0]                   bresp;
		logic                         arready;
		logic                         rvalid;
		logic [31:0]                  rdata;
		logic [1:0]                   rresp;
	} dsb_state_t;

	localparam dsb_state_t ST_RST = '{cfg: CFG_RST, awready: 1'b1, wready: 1'b1,
		arready: 1'b1, default: '0};

endpackage : dsb_pkg

//--- hdl/dsb_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
module dsb_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output      logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : dsb_sync

//--- bench/dsb_ctl.sv
// Controller model: link clock, commands and write bursts
`timescale 1ns/1ps
module dsb_ctl (
	input  wire logic              clk,
	output      logic              ck_t,
	output      dsb_pkg::dsb_cmd_t cmd,
	output      logic [15:0]       dq,
	output      logic [1:0]        stb,
	output      logic [1:0]        dm
);
	initial begin
		ck_t = 1'b0;
		cmd = '1;
		dq = 16'h0000;
		stb = 2'h3;
		dm = 2'h0;
	end
	task automatic half(input logic t);
		ck_t <= t;
		repeat (4) @(posedge clk);
	endtask : half
	task automatic issue(input logic [18:0] c, input int n);
		cmd <= c;
		@(posedge clk);
		half(1'b1);
		cmd <= {4'h7, ~c[14:0]};
		half(1'b0);
		repeat (n) begin
			half(1'b1);
			half(1'b0);
		end
	endtask : issue
	task automatic wburst(input logic [31:0] d, input logic [3:0] m);
		stb <= 2'h0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 2; i++) begin
			dq <= d[16*i +: 16];
			dm <= m[2*i +: 2];
			repeat (2) @(posedge clk);
			stb <= {2{~i[0]}};
			repeat (2) @(posedge clk);
		end
		dq <= ~d[31:16];
		stb <= 2'h3;
	endtask : wburst
endmodule : dsb_ctl

//--- bench/tb_dsb_ddr_device.sv
// Testbench for the DDR device-side burst interface
`timescale 1ns/1ps
module tb_dsb_ddr_device;
	logic CLK = 1'b0, RST_N = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
	logic S_AXI_ARVALID = 1'b0, S_AXI_BREADY = 1'b1, S_AXI_RREADY = 1'b1, sl = 1'b0;
	logic cke = 1'b1;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
	logic ck, DATA_OE, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0] cstb, cdm, STROBE_O, STROBE_OE, S_AXI_BRESP, S_AXI_RRESP;
	logic [15:0] cdq, DATA_O;
	logic [15:0] beats[$];
	dsb_pkg::dsb_cmd_t cmd;
	int failures = 0, n_tests = 0, cyc = 0;
	always #20 CLK = ~CLK;
	dsb_ctl ctl (.clk(CLK), .ck_t(ck), .cmd, .dq(cdq), .stb(cstb), .dm(cdm));
	dsb_ddr_device dut (.CLK, .RST_N, .CLOCK_TRUE(ck), .CLOCK_COMPLEMENT(~ck),
		.CLOCK_ENABLE(cke), .CHIP_SEL_N(cmd.cs_n), .ROW_STROBE_N(cmd.ras_n),
		.COL_STROBE_N(cmd.cas_n), .WRITE_EN_N(cmd.we_n), .BANK_SEL(cmd.bank),
		.ADDR(cmd.addr), .DATA_I(DATA_OE ? DATA_O : cdq), .DATA_O, .DATA_OE,
		.STROBE_I(STROBE_O & STROBE_OE | cstb & ~STROBE_OE), .STROBE_O, .STROBE_OE,
		.WRITE_MASK(cdm), .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
		.S_AXI_WDATA, .S_AXI_WSTRB(4'hF), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
		.S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
		.S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
	task automatic end_sim();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		do begin
			@(posedge CLK);
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (S_AXI_BVALID !== 1'b1);
		chk(32'(S_AXI_BRESP), 32'(r));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		do begin
			@(posedge CLK);
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (S_AXI_RVALID !== 1'b1);
		chk(S_AXI_RDATA, d);
		chk(32'(S_AXI_RRESP), 32'(r));
	endtask : rd
	function automatic logic [18:0] mk(input logic [2:0] op, input logic [1:0] b,
		input logic [12:0] a);
		return {1'b0, op, b, a};
	endfunction : mk
	// Data beats are counted on every rising or falling edge of the lower read strobe
	task automatic rburst(input logic [18:0] c, input int n, input logic [31:0] e);
		beats.delete();
		ctl.issue(c, n);
		chk(32'(beats.size()), 32'(n == 6 ? 2 : 8));
		if (n == 6)
			chk({beats[1], beats[0]}, e);
	endtask : rburst
	always @(posedge CLK) begin
		if (DATA_OE === 1'b1 && STROBE_OE[0] === 1'b1 && STROBE_O[0] !== sl)
			beats.push_back(DATA_O);
		sl <= STROBE_O[0];
	end
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (4) @(posedge CLK);
		rd(8'h00, 32'h22, 2'h0);
		wr(8'h00, 32'h21, 2'h0);
		rd(8'h00, 32'h21, 2'h0);
		wr(8'h08, 32'h21, 2'h2);
		rd(8'h0C, 32'h00, 2'h2);
		$display("test registers done");
		ctl.issue({1'b1, dsb_pkg::CMD_ACT, 2'h2, 13'h0007}, 1);
		ctl.issue(mk(dsb_pkg::CMD_ACT, 2'h1, 13'h0123), 1);
		cke <= 1'b0;
		ctl.issue(mk(dsb_pkg::CMD_ACT, 2'h3, 13'h0005), 1);
		cke <= 1'b1;
		rd(dsb_pkg::OFS_STATUS, 32'h2, 2'h0);
		rd(8'h14, 32'h123, 2'h0);
		$display("test activate done");
		fork
			ctl.issue(mk(dsb_pkg::CMD_WR, 2'h1, 13'h0004), 3);
			begin
				repeat (8) @(posedge CLK);
				ctl.wburst(32'h1234A55A, 4'h0);
			end
		join
		// Second burst over the same columns, each burst needs its own command
		fork
			ctl.issue(mk(dsb_pkg::CMD_WR, 2'h1, 13'h0004), 3);
			begin
				repeat (8) @(posedge CLK);
				ctl.wburst(32'hEEEEFFFF, 4'hE);
			end
		join
		rburst(mk(dsb_pkg::CMD_RD, 2'h1, 13'h0004), 6, 32'h1234A5FF);
		wr(8'h00, 32'h25, 2'h0);
		rburst(mk(dsb_pkg::CMD_RD, 2'h1, 13'h0404), 6, 32'h1234A5FF);
		rd(dsb_pkg::OFS_STATUS, 32'h0, 2'h0);
		$display("test burst data done");
		wr(8'h00, 32'h19, 2'h0);
		ctl.issue(mk(dsb_pkg::CMD_ACT, 2'h1, 13'h0123), 1);
		rburst(mk(dsb_pkg::CMD_RD, 2'h1, 13'h0C05), 6, 32'h00FF0034);
		rd(dsb_pkg::OFS_STATUS, 32'h0, 2'h0);
		$display("test narrow width done");
		wr(8'h00, 32'h23, 2'h0);
		ctl.issue(mk(dsb_pkg::CMD_ACT, 2'h0, 13'h0001), 1);
		ctl.issue(mk(dsb_pkg::CMD_ACT, 2'h3, 13'h0002), 1);
		rd(dsb_pkg::OFS_STATUS, 32'h9, 2'h0);
		rburst(mk(dsb_pkg::CMD_RD, 2'h0, 13'h0000), 8, 32'h0);
		ctl.issue(mk(dsb_pkg::CMD_PRE, 2'h0, 13'h0400), 1);
		rd(dsb_pkg::OFS_STATUS, 32'h0, 2'h0);
		$display("test banks done");
		end_sim();
	end
endmodule : tb_dsb_ddr_device
